// [shared/sac_pkg.sv]
`default_nettype none
package sac_pkg;
  // result width of one conversion
  localparam int RES_BITS          = 12;
  // conversion clock periods per sample: 4 sample, 12 decisions, 1 settle, 1 idle
  localparam int CLKS_PER_SAMPLE   = 18;
  localparam int SAMPLE_CLKS       = 4;
  // conversion clock frequency range in hz
  localparam int CONV_CLK_MIN_HZ   = 1000000;
  localparam int CONV_CLK_MAX_HZ   = 18000000;
  // core clock period in ns
  localparam int CLK_PERIOD_NS     = 50;
  // power-up wait in ns and its cycle count, rounded up
  localparam int PWRUP_WAIT_NS     = 10000;
  localparam int PWRUP_WAIT_CLKS   =
    (PWRUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // buffer depth between converter and reader
  localparam int BUF_DEPTH         = 2;
  // converter states
  typedef enum logic [2:0] {
    SAC_PWRUP,
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_DECIDE,
    SAC_SETTLE
  } sac_state_t;
endpackage
`default_nettype wire

// [shared/sac_if.sv]
`timescale 1ns/1ns
`default_nettype none
// link between converter control and the result reader
interface sac_if;
  import sac_pkg::*;
  logic [RES_BITS-1:0] result;   // head result word
  logic                done;     // conversion done, held until read
  logic                rd;       // reader takes the head word
  modport conv (output result, output done, input rd);
  modport rdr  (input result, input done, output rd);
endinterface
`default_nettype wire

// [design/sac_reader.sv]
`timescale 1ns/1ns
`default_nettype none
module sac_reader (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  sac_if.rdr                               lnk,
  input  wire logic                        user_ready,
  output logic [sac_pkg::RES_BITS-1:0]     user_data,
  output logic                             user_valid
);
  import sac_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state
  logic                 rd_q;        // read strobe, registered
  logic                 next_rd_q;
  logic [RES_BITS-1:0]  next_user_data;
  logic                 next_user_valid;

  ////////////////////////////////////////////////////////////////////
  // take a word only when our own output slot is free or freed this cycle; one
  // read per two cycles so done and result have updated before we look again
  always_comb begin
    next_rd_q       = 1'b0;
    next_user_data  = user_data;
    next_user_valid = user_valid;
    if (user_valid && user_ready) begin
      next_user_valid = 1'b0;
    end
    if (lnk.done && !rd_q && (!user_valid || user_ready)) begin
      next_rd_q       = 1'b1;
      next_user_data  = lnk.result;
      next_user_valid = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_q       <= 1'b0;
      user_data  <= '0;
      user_valid <= 1'b0;
    end else begin
      rd_q       <= next_rd_q;
      user_data  <= next_user_data;
      user_valid <= next_user_valid;
    end
  end

  assign lnk.rd = rd_q;
endmodule
`default_nettype wire

// [design/sac_conv.sv]
`timescale 1ns/1ns
`default_nettype none
module sac_conv #(
  parameter int PWRUP_CLKS = sac_pkg::PWRUP_WAIT_CLKS
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  sac_if.conv                              lnk,
  input  wire logic                        sw_start,
  input  wire logic                        hw_trigger,
  input  wire logic                        single_conversion_select,
  input  wire logic                        wake,
  input  wire logic                        comp_in,
  output logic [sac_pkg::RES_BITS-1:0]     dac_code,
  output logic                             sample_en,
  output logic                             done_flag,
  output logic                             busy
);
  import sac_pkg::*;

  // wide enough for the wait and for every phase count of a frame
  localparam int CW = $clog2(PWRUP_CLKS + CLKS_PER_SAMPLE + 1);
  // the idle cycle between frames is the last clock of the eighteen, so
  // back-to-back continuous frames keep the sample rate exact
  localparam int SETTLE_CLKS = CLKS_PER_SAMPLE - SAMPLE_CLKS - RES_BITS - 1;

  ////////////////////////////////////////////////////////////////////
  // trigger synchroniser: pin from outside, three flops
  logic [2:0] trig_sync;
  logic       trig_lvl;        // filtered level
  logic       next_trig_lvl;
  logic       trig_rise;

  always_comb begin
    next_trig_lvl = trig_lvl;
    // change counts once second and third stage agree
    if (trig_sync[1] == trig_sync[2]) begin
      next_trig_lvl = trig_sync[2];
    end
  end
  assign trig_rise = next_trig_lvl && !trig_lvl;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trig_sync <= 3'h0;
      trig_lvl  <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[1:0], hw_trigger};
      trig_lvl  <= next_trig_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // converter state
  sac_state_t          state, next_state;
  logic [CW-1:0]       cnt, next_cnt;          // wait / phase counter
  logic [3:0]          bit_idx, next_bit_idx;  // bit under test
  logic [RES_BITS-1:0] next_dac_code;
  logic                pend, next_pend;        // held start request
  logic                next_sample_en;
  logic                next_busy;
  logic                push;                   // result into buffer
  logic                buf_ready;              // buffer can take one
  logic                start_req;

  // a start is a software write or a trigger edge
  assign start_req = sw_start || trig_rise;

  ////////////////////////////////////////////////////////////////////
  // next-state logic for the conversion sequence
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_bit_idx   = bit_idx;
    next_dac_code  = dac_code;
    next_pend      = pend || start_req;
    next_sample_en = 1'b0;
    next_busy      = 1'b1;
    push           = 1'b0;
    unique case (state)
      SAC_PWRUP: begin
        // starts are remembered, not acted on, until ready
        if (cnt == CW'(PWRUP_CLKS - 1)) begin
          next_state = SAC_IDLE;
          next_busy  = 1'b0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      SAC_IDLE: begin
        next_busy = 1'b0;
        // both modes wait for buffer room; continuous needs no start, single_conversion_select waits for a start
        if ((pend || !single_conversion_select) && buf_ready) begin
          next_state     = SAC_SAMPLE;
          next_pend      = 1'b0;
          next_cnt       = '0;
          next_sample_en = 1'b1;
          next_busy      = 1'b1;
        end
      end
      SAC_SAMPLE: begin
        next_sample_en = 1'b1;
        if (cnt == CW'(SAMPLE_CLKS - 1)) begin
          next_state     = SAC_DECIDE;
          next_sample_en = 1'b0;
          next_bit_idx   = 4'(RES_BITS - 1);
          // trial code: msb set, all lower clear
          next_dac_code  = {1'b1, {(RES_BITS-1){1'b0}}};
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      SAC_DECIDE: begin
        // comparator high means input below dac: drop the trial bit
        if (comp_in) begin
          next_dac_code[bit_idx] = 1'b0;
        end
        if (bit_idx == 4'h0) begin
          next_state = SAC_SETTLE;
          next_cnt   = '0;
        end else begin
          next_bit_idx                 = bit_idx - 1'b1;
          next_dac_code[bit_idx - 1'b1] = 1'b1;
        end
      end
      SAC_SETTLE: begin
        // pad to eighteen clocks per sample
        if (cnt == CW'(SETTLE_CLKS - 1)) begin
          next_state = SAC_IDLE;
          push       = 1'b1;
          next_busy  = 1'b0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    endcase
    // wake from sleep restarts the wait; a conversion not yet pushed is lost
    if (wake) begin
      next_state = SAC_PWRUP;
      next_cnt   = '0;
      next_busy  = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state     <= SAC_PWRUP;
      cnt       <= '0;
      bit_idx   <= 4'h0;
      dac_code  <= '0;
      pend      <= 1'b0;
      sample_en <= 1'b0;
      busy      <= 1'b1;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      bit_idx   <= next_bit_idx;
      dac_code  <= next_dac_code;
      pend      <= next_pend;
      sample_en <= next_sample_en;
      busy      <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // two-entry result buffer; done stands while any word waits
  logic [RES_BITS-1:0] mem [BUF_DEPTH];
  logic [RES_BITS-1:0] next_mem [BUF_DEPTH];
  logic [1:0]          count, next_count;
  logic                next_done;
  logic                pop;

  assign buf_ready = (count != 2'(BUF_DEPTH)); // stalls the converter
  // a read strobe while empty is ignored
  assign pop = lnk.rd && (count != 2'h0);

  always_comb begin
    next_mem   = mem;
    next_count = count;
    if (pop) begin
      next_mem[0] = mem[1];
      next_count  = next_count - 1'b1;
    end
    if (push) begin
      next_mem[next_count[0]] = next_dac_code;
      next_count              = next_count + 1'b1;
    end
    // new word wins over the read that clears it
    next_done = (next_count != 2'h0);
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem[0]    <= '0;
      mem[1]    <= '0;
      count     <= 2'h0;
      done_flag <= 1'b0;
    end else begin
      mem       <= next_mem;
      count     <= next_count;
      done_flag <= next_done;
    end
  end

  assign lnk.done   = done_flag;
  assign lnk.result = mem[0];
endmodule
`default_nettype wire

// [verification/sac_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module sac_chk #(
  parameter int PWRUP_CLKS = sac_pkg::PWRUP_WAIT_CLKS
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic [sac_pkg::RES_BITS-1:0] result,
  input  wire logic                        done,
  input  wire logic                        rd
);
  import sac_pkg::*;
  logic [15:0] cnt;       // cycles since reset released
  logic [15:0] next_cnt;  // next count, saturating
  //////////////////////////////////////////////////////////////////////////
  // saturate so the wait check stays quiet for the rest of the run
  always_comb begin
    next_cnt = (cnt == 16'hffff) ? cnt : cnt + 16'h1;
    if (sys_rst) begin
      next_cnt = 16'h0;
    end
  end
  always_ff @(posedge core_clk) begin
    cnt <= next_cnt;
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // reset clears the link; checked without the default disable
  reset_link_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> !done && !rd) else $error("link active after reset");
  // wait plus one full frame before the first word can show
  pwrup_wait_a: assert property
    (int'(cnt) < PWRUP_CLKS + CLKS_PER_SAMPLE |-> !done)
    else $error("done during power-up wait");
  done_hold_a: assert property (done && !rd |=> done)
    else $error("done dropped without a read");
  done_fall_a: assert property ($fell(done) |-> $past(rd))
    else $error("done fell with no read before it");
  result_stable_a: assert property (done && !rd |=> $stable(result))
    else $error("result moved while unread");
  rd_single_a: assert property (rd |=> !rd)
    else $error("reads on adjacent cycles");
  rd_done_a: assert property (rd |-> done)
    else $error("read with no word waiting");
  // the reader registers rd, so it cannot answer in the rising cycle
  rise_no_rd_a: assert property ($rose(done) |-> !rd)
    else $error("read in the cycle done rose");
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sac_pkg::*;
  localparam int PW = 5;  // short power-up wait for simulation
  logic core_clk = 0, sys_rst = 1, sw_start = 0, hw_trigger = 0;
  logic single_conversion_select = 1, wake = 0, user_ready = 0;
  logic [11:0] ain = 12'h0;  // analog level seen by the comparator
  logic [11:0] dac_code, user_data;
  logic        comp_in, sample_en, done_flag, busy, user_valid;
  int          err_count = 0, tests_run = 0;
  int          gap, hi;  // measured frame length and sample strobe width
  sac_if lnk();
  // comparator: high when input is below the trial code
  assign comp_in = (ain < dac_code);
  always #25 core_clk = ~core_clk;
  sac_conv #(.PWRUP_CLKS(PW)) i_sac_conv (.core_clk(core_clk),
    .sys_rst(sys_rst), .lnk(lnk), .sw_start(sw_start),
    .hw_trigger(hw_trigger), .wake(wake), .comp_in(comp_in),
    .single_conversion_select(single_conversion_select),
    .dac_code(dac_code), .sample_en(sample_en), .done_flag(done_flag),
    .busy(busy));
  sac_reader i_sac_reader (.core_clk(core_clk), .sys_rst(sys_rst),
    .lnk(lnk), .user_ready(user_ready), .user_data(user_data),
    .user_valid(user_valid));
  sac_chk #(.PWRUP_CLKS(PW)) i_sac_chk (.core_clk(core_clk),
    .sys_rst(sys_rst), .result(lnk.result), .done(lnk.done), .rd(lnk.rd));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d of %0d compares", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic start;
    sw_start <= 1'b1;
    @(posedge core_clk);
    sw_start <= 1'b0;
  endtask
  // bounded wait; one spare edge so the next call sees fresh valid
  task automatic read_word(input logic [11:0] exp);
    int n;
    n = 0;
    while (user_valid !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk({11'h0, user_valid}, 12'h1);
    chk(user_data, exp);
    user_ready <= 1'b1;
    @(posedge core_clk);
    user_ready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic no_word;
    repeat (60) @(posedge core_clk);
    chk({11'h0, user_valid}, 12'h0);
    chk({11'h0, done_flag}, 12'h0);
  endtask
  // cycles from one rising sample strobe to the next, and its high time
  task automatic frame_len(output int gap, output int hi);
    int n;
    n = 0;
    gap = 0;
    hi = 0;
    while (sample_en !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    while (sample_en !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    while (sample_en === 1'b1 && gap < 100) begin
      @(posedge core_clk);
      hi++;
      gap++;
    end
    while (sample_en !== 1'b1 && gap < 100) begin
      @(posedge core_clk);
      gap++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  logic [11:0] vals [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c};
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    ain <= 12'h5a3;
    @(posedge core_clk);
    chk({11'h0, busy}, 12'h1);
    start;
    read_word(12'h5a3);
    chk(dac_code, 12'h5a3);
    foreach (vals[i]) begin
      ain <= vals[i];
      start;
      read_word(vals[i]);
    end
    // three starts in a row make exactly two results
    ain <= 12'h3c6;
    start;
    start;
    start;
    read_word(12'h3c6);
    read_word(12'h3c6);
    no_word;
    hw_trigger <= 1'b1;
    read_word(12'h3c6);
    no_word;
    hw_trigger <= 1'b0;
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({11'h0, busy}, 12'h1);
    start;
    read_word(12'h3c6);
    // continuous: reader stalls until the buffer is full
    ain <= 12'h0e1;
    single_conversion_select <= 1'b0;
    repeat (150) @(posedge core_clk);
    chk({11'h0, done_flag}, 12'h1);
    repeat (4) read_word(12'h0e1);
    // reader drains freely, so frames run back to back
    user_ready <= 1'b1;
    frame_len(gap, hi);
    chk(12'(gap), 12'(CLKS_PER_SAMPLE));
    chk(12'(hi), 12'(SAMPLE_CLKS));
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
